//--- common/tmps_if.sv
// Per-probe match results passed from the matcher to the selector.
// Assumes both ends run in the same clock cycle (combinational path).
`default_nettype none

interface tmps_if #(
  parameter int NP = 3
);
  logic [NP-1:0] hit;
  logic [NP-1:0] rxHit;

  modport producer (
    output hit,
    output rxHit
  );

  modport consumer (
    input hit,
    input rxHit
  );
endinterface : tmps_if

`default_nettype wire

//--- common/tmps_params.svh
// Constants of the traffic mirror probe selector: field positions,
// encodings, default sizes and reset values.
// Assumes it is included by bare name, from common/.
`ifndef TMPS_PARAMS_SVH
`define TMPS_PARAMS_SVH

// ********************************
// Probe count and sizes
// ********************************
`define TMPS_NUM_PROBES 3
`define TMPS_DFLT_PORTS 12
`define TMPS_DFLT_CPUS 8
`define TMPS_DFLT_DEST_W 5
`define TMPS_VID_W 12
`define TMPS_MAX_PORTS 64

// ********************************
// Field positions and encodings
// ********************************
`define TMPS_DIR_TX_BIT 0
`define TMPS_DIR_RX_BIT 1
`define TMPS_STN_DST_BIT 0
`define TMPS_STN_SRC_BIT 1
`define TMPS_VLAN_ANY 2'h0
`define TMPS_VLAN_ENTRY 2'h1
`define TMPS_VLAN_VID 2'h2
`define TMPS_VLAN_RSVD 2'h3

// ********************************
// Reset values
// ********************************
`define TMPS_RST_BIT 1'h0

`endif

//--- common/tmps_pkg.sv
// Types shared by the traffic mirror probe selector modules.
// Assumes tmps_params.svh is on the include path.
`include "tmps_params.svh"
`default_nettype none

package tmps_pkg;

  // ********************************
  // Probe VLAN filter modes
  // ********************************
  typedef enum logic [1:0] {
    TMPS_VLAN_OFF = `TMPS_VLAN_ANY,
    TMPS_VLAN_FLAG = `TMPS_VLAN_ENTRY,
    TMPS_VLAN_ID = `TMPS_VLAN_VID,
    TMPS_VLAN_NONE = `TMPS_VLAN_RSVD
  } tmps_vlan_mode_type;

  // Kind of copy handed to the rewriter
  typedef enum logic {
    TMPS_COPY_RX = 1'b0,
    TMPS_COPY_TX = 1'b1
  } tmps_copy_kind_type;

endpackage : tmps_pkg

`default_nettype wire

//--- rtl/tmps_copy_sel.sv
// Picks the one probe that yields the mirror copy of a frame.
// Assumes the hit vectors come from tmps_probe_match in the same cycle.
`default_nettype none

module tmps_copy_sel #(
  parameter int NP = 3
) (
  // Match results
  tmps_if.consumer res,
  // Choice
  output logic selAny,
  output logic [1:0] selProbe,
  output logic selRx
);
  import tmps_pkg::*;

  always_comb begin
    selAny = 1'b0;
    selProbe = 2'h0;
    selRx = 1'b0;
    for (int p = 0; p < NP; p++) begin
      if (res.hit[p]) begin
        selAny = 1'b1;
        selProbe = 2'(p);
        selRx = res.rxHit[p];
      end
    end
  end
endmodule : tmps_copy_sel

`default_nettype wire

//--- rtl/tmps_probe_match.sv
// Filter evaluation of every probe against one frame.
// Assumes frame and probe settings are stable for the cycle.
`include "tmps_params.svh"
`default_nettype none

module tmps_probe_match #(
  parameter int NP = 3,
  parameter int NPORT = 12,
  parameter int NCPU = 8,
  parameter int PIW = 4
) (
  // Frame
  input wire logic [PIW-1:0] rxPort,
  input wire logic [PIW-1:0] masqPort,
  input wire logic [NCPU:0] cpuVdSrc,
  input wire logic [NPORT-1:0] egressMask,
  input wire logic [NCPU-1:0] cpuDestMask,
  input wire logic [`TMPS_VID_W-1:0] vid,
  input wire logic vlanEntryCopyFlag,
  input wire logic srcStationCopy,
  input wire logic dstStationCopy,
  input wire logic flooded,
  input wire logic clsValid,
  input wire logic [1:0] clsProbe,
  input wire logic floodedCopyEnable,
  // Probe settings
  input wire logic [NP-1:0][1:0] probeDirection,
  input wire logic [NP-1:0][1:0] stationFilterSel,
  input wire logic [NP-1:0][1:0] vlanFilterSel,
  input wire logic [NP-1:0][`TMPS_VID_W-1:0] matchVlanId,
  input wire logic [NP-1:0][NCPU-1:0] probeCpuSet,
  input wire logic [NP-1:0] usePhysicalIngressPort,
  input wire logic [NP-1:0][NCPU:0] cpuVdIngressMask,
  input wire logic [NP-1:0][NPORT-1:0] watchedPortMask,
  // Results
  tmps_if.producer res
);
  import tmps_pkg::*;

  function automatic logic portSel(
    input logic [NPORT-1:0] mask,
    input logic [PIW-1:0] idx
  );
    portSel = (int'(idx) < NPORT) ? mask[idx] : 1'b0;
  endfunction : portSel

  always_comb begin
    logic rxH;
    logic txH;
    logic vlanOk;
    logic stnOk;
    logic [1:0] dir;
    rxH = 1'b0;
    txH = 1'b0;
    vlanOk = 1'b0;
    stnOk = 1'b0;
    dir = 2'h0;
    res.hit = '0;
    res.rxHit = '0;
    for (int p = 0; p < NP; p++) begin
      dir = probeDirection[p];
      rxH = dir[`TMPS_DIR_RX_BIT] & portSel(watchedPortMask[p],
          usePhysicalIngressPort[p] ? rxPort : masqPort);
      rxH = rxH | (dir[`TMPS_DIR_RX_BIT] &
          (|(cpuVdSrc & cpuVdIngressMask[p])));
      txH = dir[`TMPS_DIR_TX_BIT] &
          ((|(egressMask & watchedPortMask[p])) |
           (|(cpuDestMask & probeCpuSet[p])));
      case (tmps_vlan_mode_type'(vlanFilterSel[p]))
        TMPS_VLAN_FLAG: vlanOk = vlanEntryCopyFlag;
        TMPS_VLAN_ID: vlanOk = (vid == matchVlanId[p]);
        default: vlanOk = 1'b1;
      endcase
      stnOk = (~stationFilterSel[p][`TMPS_STN_SRC_BIT] | srcStationCopy) &
          (~stationFilterSel[p][`TMPS_STN_DST_BIT] | dstStationCopy |
           (flooded & floodedCopyEnable));
      res.hit[p] = (rxH | txH) & vlanOk & stnOk;
      res.rxHit[p] = rxH;
      if (clsValid && int'(clsProbe) == p) begin
        res.hit[p] = |dir;
        res.rxHit[p] = dir[`TMPS_DIR_RX_BIT];
      end
    end
  end
endmodule : tmps_probe_match

`default_nettype wire

//--- rtl/tmps_top.sv
// Mirror probe selection for frames leaving the forwarding decision.
// Assumes one frame descriptor per cycle at most, inputs synchronous
// to ref_clk, and probe settings held steady while frames flow.
`include "tmps_params.svh"
`default_nettype none

// Summary of operation
// - Three independent probes, each with own filters and destination.
// - Unless classifier-assigned, a probe selects a frame only if all enabled filters agree.
// - Several matches: highest numbered probe wins, one copy only.
// - Direction bit 1: frames received on masked ports are copied.
// - Direction bit 0: frames sent on masked ports are copied.
// - Direction bit 0: frames to selected CPU ports are copied.
// - VLAN mode 2: only frames in the probe VLAN ID qualify.
// - VLAN mode 1: only VLANs whose entry copy flag is set qualify.
// - Station bit 1: frames from flagged learned stations qualify.
// - Station bit 0: to flagged stations, or flooded if enabled.
// - Classifier-assigned frames use only the probe direction.
// - Direction bit 1: frames injected from masked CPU/VD qualify.
// - Each probe sends copies to its configurable destination port.
// - Rx copies unmodified, extra Q-tag when remote mirroring on.
// - Tx copies edited for configured Tx port, optional Q-tag.
// - Direction 2 means Rx only; port mask is one bit per port.
// - Per probe, Rx port is physical or masqueraded ingress port.
module tmps_top #(
  parameter int NUM_PORTS = `TMPS_DFLT_PORTS,
  parameter int NUM_CPUS = `TMPS_DFLT_CPUS,
  parameter int DEST_W = `TMPS_DFLT_DEST_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Frame descriptor
  input wire logic frmValid,
  input wire logic [$clog2(NUM_PORTS)-1:0] frmRxPort,
  input wire logic [$clog2(NUM_PORTS)-1:0] frmMasqPort,
  input wire logic [NUM_CPUS:0] frmCpuVdSrc,
  input wire logic [NUM_PORTS-1:0] frmEgressMask,
  input wire logic [NUM_CPUS-1:0] frmCpuDestMask,
  input wire logic [`TMPS_VID_W-1:0] frmVid,
  input wire logic frmVlanEntryCopyFlag,
  input wire logic frmSrcStationCopy,
  input wire logic frmDstStationCopy,
  input wire logic frmFlooded,
  input wire logic frmClsValid,
  input wire logic [1:0] frmClsProbe,
  input wire logic [NUM_PORTS-1:0] frmFwdMask,
  // Global setting
  input wire logic floodedCopyEnable,
  // Probe settings
  input wire logic [`TMPS_NUM_PROBES-1:0][1:0] probeDirection,
  input wire logic [`TMPS_NUM_PROBES-1:0][1:0] stationFilterSel,
  input wire logic [`TMPS_NUM_PROBES-1:0][1:0] vlanFilterSel,
  input wire logic [`TMPS_NUM_PROBES-1:0][`TMPS_VID_W-1:0] matchVlanId,
  input wire logic [`TMPS_NUM_PROBES-1:0][NUM_CPUS-1:0] probeCpuSet,
  input wire logic [`TMPS_NUM_PROBES-1:0] usePhysicalIngressPort,
  input wire logic [`TMPS_NUM_PROBES-1:0][NUM_CPUS:0] cpuVdIngressMask,
  input wire logic [`TMPS_NUM_PROBES-1:0][NUM_PORTS-1:0] watchedPortMask,
  input wire logic [`TMPS_NUM_PROBES-1:0][DEST_W-1:0] copyDestPort,
  input wire logic [`TMPS_NUM_PROBES-1:0] remoteMirrorEnable,
  input wire logic [`TMPS_NUM_PROBES-1:0][$clog2(NUM_PORTS)-1:0]
      mirrorTxPort,
  // Original frame forwarding
  output logic fwdValid,
  output logic [NUM_PORTS-1:0] fwdMask,
  // Mirror copy
  output logic copyValid,
  output logic [1:0] copyProbe,
  output logic [DEST_W-1:0] copyDest,
  output logic copyIsTx,
  output logic [$clog2(NUM_PORTS)-1:0] copyEditPort,
  output logic copyAddTag
);
  import tmps_pkg::*;

  localparam int NP = `TMPS_NUM_PROBES;
  localparam int PIW = $clog2(NUM_PORTS);

  // ********************************
  // Elaboration checks
  // ********************************
  // Port index must fit a mask of at most the widest supported size
  if (NUM_PORTS < 2 || NUM_PORTS > `TMPS_MAX_PORTS) begin : g_bad_ports
    $error("tmps_top: NUM_PORTS out of range");
  end
  if (NUM_CPUS < 1 || DEST_W < PIW) begin : g_bad_cpu
    $error("tmps_top: NUM_CPUS or DEST_W out of range");
  end

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic valid;
    logic [PIW-1:0] rxPort;
    logic [PIW-1:0] masqPort;
    logic [NUM_CPUS:0] cpuVdSrc;
    logic [NUM_PORTS-1:0] egressMask;
    logic [NUM_CPUS-1:0] cpuDestMask;
    logic [`TMPS_VID_W-1:0] vid;
    logic vlanFlag;
    logic srcStn;
    logic dstStn;
    logic flooded;
    logic clsValid;
    logic [1:0] clsProbe;
    logic [NUM_PORTS-1:0] fwdMask;
  } tmps_frame_type;

  typedef struct packed {
    tmps_frame_type frm;
    logic fwdValid;
    logic [NUM_PORTS-1:0] fwdMask;
    logic copyValid;
    logic [1:0] copyProbe;
    logic [DEST_W-1:0] copyDest;
    logic copyIsTx;
    logic [PIW-1:0] copyEditPort;
    logic copyAddTag;
  } tmps_state_type;

  tmps_state_type st_ff;
  tmps_state_type nxt_st;

  logic selAny;
  logic [1:0] selProbe;
  logic selRx;

  // ********************************
  // Probe evaluation
  // ********************************
  tmps_if #(.NP(NP)) matchBus ();

  tmps_probe_match #(
    .NP(NP),
    .NPORT(NUM_PORTS),
    .NCPU(NUM_CPUS),
    .PIW(PIW)
  ) u_match (
    .rxPort(st_ff.frm.rxPort),
    .masqPort(st_ff.frm.masqPort),
    .cpuVdSrc(st_ff.frm.cpuVdSrc),
    .egressMask(st_ff.frm.egressMask),
    .cpuDestMask(st_ff.frm.cpuDestMask),
    .vid(st_ff.frm.vid),
    .vlanEntryCopyFlag(st_ff.frm.vlanFlag),
    .srcStationCopy(st_ff.frm.srcStn),
    .dstStationCopy(st_ff.frm.dstStn),
    .flooded(st_ff.frm.flooded),
    .clsValid(st_ff.frm.clsValid),
    .clsProbe(st_ff.frm.clsProbe),
    .floodedCopyEnable(floodedCopyEnable),
    .probeDirection(probeDirection),
    .stationFilterSel(stationFilterSel),
    .vlanFilterSel(vlanFilterSel),
    .matchVlanId(matchVlanId),
    .probeCpuSet(probeCpuSet),
    .usePhysicalIngressPort(usePhysicalIngressPort),
    .cpuVdIngressMask(cpuVdIngressMask),
    .watchedPortMask(watchedPortMask),
    .res(matchBus.producer)
  );

  tmps_copy_sel #(
    .NP(NP)
  ) u_sel (
    .res(matchBus.consumer),
    .selAny(selAny),
    .selProbe(selProbe),
    .selRx(selRx)
  );

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    nxt_st = st_ff;
    // Descriptor capture; a new frame may follow every cycle
    nxt_st.frm.valid = frmValid;
    nxt_st.frm.rxPort = frmRxPort;
    nxt_st.frm.masqPort = frmMasqPort;
    nxt_st.frm.cpuVdSrc = frmCpuVdSrc;
    nxt_st.frm.egressMask = frmEgressMask;
    nxt_st.frm.cpuDestMask = frmCpuDestMask;
    nxt_st.frm.vid = frmVid;
    nxt_st.frm.vlanFlag = frmVlanEntryCopyFlag;
    nxt_st.frm.srcStn = frmSrcStationCopy;
    nxt_st.frm.dstStn = frmDstStationCopy;
    nxt_st.frm.flooded = frmFlooded;
    nxt_st.frm.clsValid = frmClsValid;
    nxt_st.frm.clsProbe = frmClsProbe;
    nxt_st.frm.fwdMask = frmFwdMask;
    nxt_st.fwdValid = st_ff.frm.valid;
    nxt_st.fwdMask = st_ff.frm.fwdMask;
    // at most one copy per frame
    nxt_st.copyValid = st_ff.frm.valid & selAny;
    nxt_st.copyProbe = selProbe;
    nxt_st.copyDest = copyDestPort[selProbe];
    nxt_st.copyIsTx = selRx ? TMPS_COPY_RX : TMPS_COPY_TX;
    // Tx copy edited for Tx port
    nxt_st.copyEditPort = selRx ? '0 : mirrorTxPort[selProbe];
    nxt_st.copyAddTag = remoteMirrorEnable[selProbe];
    // Idle cycles show cleared copy fields, not stale choices
    if (!(st_ff.frm.valid && selAny)) begin
      nxt_st.copyProbe = 2'h0;
      nxt_st.copyDest = '0;
      nxt_st.copyIsTx = `TMPS_RST_BIT;
      nxt_st.copyEditPort = '0;
      nxt_st.copyAddTag = `TMPS_RST_BIT;
    end
    if (!st_ff.frm.valid) begin
      nxt_st.fwdMask = '0;
    end
    if (!rst_n) begin
      nxt_st = '0;
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign fwdValid = st_ff.fwdValid;
  assign fwdMask = st_ff.fwdMask;
  assign copyValid = st_ff.copyValid;
  assign copyProbe = st_ff.copyProbe;
  assign copyDest = st_ff.copyDest;
  assign copyIsTx = st_ff.copyIsTx;
  assign copyEditPort = st_ff.copyEditPort;
  assign copyAddTag = st_ff.copyAddTag;
endmodule : tmps_top

`default_nettype wire

//--- verification/tmps_pipe_model.sv
// Downstream pipeline model: takes forward results and mirror copies.
// Assumes results arrive as one-cycle pulses on ref_clk.
`default_nettype none
module tmps_pipe_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Results
  input wire logic fwdValid,
  input wire logic copyValid
);
  timeunit 1ns;
  timeprecision 1ps;
  int fwdCnt;
  int copyCnt;
  // Counts only; frame bodies are not modelled
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      fwdCnt <= 0;
      copyCnt <= 0;
    end else begin
      fwdCnt <= fwdCnt + int'(fwdValid);
      copyCnt <= copyCnt + int'(copyValid);
    end
  end
endmodule : tmps_pipe_model
`default_nettype wire

//--- verification/tmps_top_assertions.sv
// Checker on the ports of the mirror probe selector.
// Assumes one clock, ref_clk, and synchronous active-low rst_n.
`include "tmps_params.svh"
`default_nettype none
module tmps_top_assertions #(
  parameter int NUM_PORTS = 12,
  parameter int NUM_CPUS = 8,
  parameter int DEST_W = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched inputs
  input wire logic frmValid,
  input wire logic frmClsValid,
  input wire logic [1:0] frmClsProbe,
  input wire logic [NUM_PORTS-1:0] frmFwdMask,
  input wire logic [`TMPS_NUM_PROBES-1:0][1:0] probeDirection,
  input wire logic [`TMPS_NUM_PROBES-1:0][DEST_W-1:0] copyDestPort,
  input wire logic [`TMPS_NUM_PROBES-1:0] remoteMirrorEnable,
  input wire logic [`TMPS_NUM_PROBES-1:0][$clog2(NUM_PORTS)-1:0]
      mirrorTxPort,
  // Watched outputs
  input wire logic fwdValid,
  input wire logic [NUM_PORTS-1:0] fwdMask,
  input wire logic copyValid,
  input wire logic [1:0] copyProbe,
  input wire logic [DEST_W-1:0] copyDest,
  input wire logic copyIsTx,
  input wire logic [$clog2(NUM_PORTS)-1:0] copyEditPort,
  input wire logic copyAddTag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Settings of the evaluation cycle; outputs stand one edge later,
  // when the bench may already have moved on to new settings
  logic [`TMPS_NUM_PROBES-1:0][DEST_W-1:0] destPort_ff;
  logic [`TMPS_NUM_PROBES-1:0] remoteTag_ff;
  logic [`TMPS_NUM_PROBES-1:0][$clog2(NUM_PORTS)-1:0] txPort_ff;
  always_ff @(posedge ref_clk) begin
    destPort_ff <= copyDestPort;
    remoteTag_ff <= remoteMirrorEnable;
    txPort_ff <= mirrorTxPort;
  end
  // ********************************
  // Properties
  // ********************************
  property p_fwd;
    frmValid |-> ##2 (fwdValid && fwdMask == $past(frmFwdMask, 2));
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forward result lost or altered");
  property p_idle;
    !frmValid |-> ##2 !(fwdValid || copyValid);
  endproperty
  a_idle: assert property (p_idle)
    else $error("output without a frame");
  property p_single;
    copyValid |-> fwdValid && copyProbe != 2'h3;
  endproperty
  a_single: assert property (p_single)
    else $error("copy without its frame");
  property p_dest;
    copyValid |-> copyDest == destPort_ff[copyProbe];
  endproperty
  a_dest: assert property (p_dest)
    else $error("copy sent to wrong port");
  property p_tag;
    copyValid |-> copyAddTag == remoteTag_ff[copyProbe];
  endproperty
  a_tag: assert property (p_tag)
    else $error("extra tag flag wrong");
  property p_rx_edit;
    copyValid && !copyIsTx |-> copyEditPort == '0;
  endproperty
  a_rx_edit: assert property (p_rx_edit)
    else $error("rx copy edited");
  property p_tx_edit;
    copyValid && copyIsTx |-> copyEditPort == txPort_ff[copyProbe];
  endproperty
  a_tx_edit: assert property (p_tx_edit)
    else $error("tx copy edit port wrong");
  // Probe 2 is the highest, so a classifier pick of it wins whenever its direction is nonzero
  property p_cls;
    frmValid && frmClsValid && frmClsProbe == 2'h2 &&
        probeDirection[2] != 2'h0 |-> ##2 copyValid && copyProbe == 2'h2;
  endproperty
  a_cls: assert property (p_cls)
    else $error("classifier probe not taken");
  c_rx: cover property (copyValid && !copyIsTx);
  c_tx: cover property (copyValid && copyIsTx);
  c_top: cover property (copyValid && copyProbe == 2'h2);
endmodule : tmps_top_assertions

bind tmps_top tmps_top_assertions #(
  .NUM_PORTS(NUM_PORTS),
  .NUM_CPUS(NUM_CPUS),
  .DEST_W(DEST_W)
) i_tmps_top_assertions (.*);
`default_nettype wire

//--- verification/tmps_top_bench.sv
// Self-checking bench of the mirror probe selector.
// Assumes default parameters and a two-cycle result latency.
`default_nettype none
module tmps_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, frmValid, frmVlanEntryCopyFlag, frmSrcStationCopy;
  logic frmDstStationCopy, frmFlooded, frmClsValid, floodedCopyEnable;
  logic fwdValid, copyValid, copyIsTx, copyAddTag;
  logic [1:0] frmClsProbe, copyProbe;
  logic [3:0] frmRxPort, frmMasqPort, copyEditPort;
  logic [4:0] copyDest;
  logic [7:0] frmCpuDestMask;
  logic [8:0] frmCpuVdSrc;
  logic [11:0] frmEgressMask, frmFwdMask, frmVid, fwdMask;
  logic [2:0][1:0] probeDirection, stationFilterSel, vlanFilterSel;
  logic [2:0][11:0] matchVlanId, watchedPortMask;
  logic [2:0][7:0] probeCpuSet;
  logic [2:0][8:0] cpuVdIngressMask;
  logic [2:0][4:0] copyDestPort;
  logic [2:0][3:0] mirrorTxPort;
  logic [2:0] usePhysicalIngressPort, remoteMirrorEnable;
  int error_cnt, checks, expCopies, expFwds;
  tmps_top i_tmps_top (.*);
  tmps_pipe_model i_tmps_pipe_model (.*);
  // ********************************
  // Shared tasks
  // ********************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_copy(input logic [13:0] exp);
    if (exp[13]) expCopies++;
    chk_val({2'h0, copyValid, copyProbe, copyDest, copyIsTx, copyEditPort,
        copyAddTag}, {2'h0, exp});
  endtask : chk_copy
  function automatic logic [13:0] cp(input logic [1:0] p,
      input logic [4:0] d, input logic tx, input logic [3:0] e,
      input logic t);
    return {1'h1, p, d, tx, e, t};
  endfunction : cp
  task automatic clr();
    {frmValid, frmVlanEntryCopyFlag, frmSrcStationCopy, frmFlooded} = '0;
    {frmDstStationCopy, frmClsValid, floodedCopyEnable, frmClsProbe} = '0;
    {frmRxPort, frmMasqPort, frmCpuVdSrc, frmEgressMask, frmVid} = '0;
    {frmCpuDestMask, frmFwdMask, probeDirection, stationFilterSel} = '0;
    {vlanFilterSel, matchVlanId, probeCpuSet, cpuVdIngressMask} = '0;
    {usePhysicalIngressPort, watchedPortMask, copyDestPort} = '0;
    {remoteMirrorEnable, mirrorTxPort} = '0;
  endtask : clr
  // Fixed latency: result stands after the second rising edge from the frame
  task automatic send(input logic [3:0] rx, input logic [11:0] eg,
      input logic [11:0] vid);
    @(negedge ref_clk);
    frmRxPort = rx;
    frmEgressMask = eg;
    frmVid = vid;
    frmFwdMask = ~eg;
    frmValid = 1'h1;
    expFwds++;
    @(negedge ref_clk);
    frmValid = 1'h0;
    @(negedge ref_clk);
    chk_val({3'h0, fwdValid, fwdMask}, {4'h1, ~eg});
  endtask : send
  // ********************************
  // Scenarios
  // ********************************
  // Reset in mid-run drops a frame in flight and clears every output
  task automatic t_rst();
    clr();
    probeDirection[0] = 2'h2;
    watchedPortMask[0] = 12'h001;
    usePhysicalIngressPort[0] = 1'h1;
    copyDestPort[0] = 5'h05;
    @(negedge ref_clk);
    frmFwdMask = 12'h00f;
    frmValid = 1'h1;
    @(negedge ref_clk);
    frmValid = 1'h0;
    rst_n = 1'h0;
    @(negedge ref_clk);
    chk_val({3'h0, fwdValid, fwdMask}, 16'h0);
    chk_copy(14'h0);
    repeat (2) @(negedge ref_clk);
    rst_n = 1'h1;
    send(4'h0, 12'h000, 12'h000);
    chk_copy(cp(2'h0, 5'h05, 1'h0, 4'h0, 1'h0));
    $display("t_rst done");
  endtask : t_rst
  task automatic t_rx();
    clr();
    probeDirection[1] = 2'h2;
    watchedPortMask[1] = 12'h008;
    vlanFilterSel[1] = 2'h2;
    matchVlanId[1] = 12'h003;
    copyDestPort[1] = 5'h0b;
    usePhysicalIngressPort[1] = 1'h1;
    mirrorTxPort[1] = 4'h6;
    send(4'h3, 12'h000, 12'h003);
    chk_copy(cp(2'h1, 5'h0b, 1'h0, 4'h0, 1'h0));
    send(4'h3, 12'h000, 12'h004);
    chk_copy(14'h0);
    usePhysicalIngressPort[1] = 1'h0;
    remoteMirrorEnable[1] = 1'h1;
    frmMasqPort = 4'h5;
    send(4'h3, 12'h000, 12'h003);
    chk_copy(14'h0);
    frmMasqPort = 4'h3;
    send(4'h5, 12'h000, 12'h003);
    chk_copy(cp(2'h1, 5'h0b, 1'h0, 4'h0, 1'h1));
    $display("t_rx done");
  endtask : t_rx
  task automatic t_tx();
    clr();
    probeDirection[0] = 2'h1;
    watchedPortMask[0] = 12'h004;
    probeCpuSet[0] = 8'h10;
    copyDestPort[0] = 5'h04;
    mirrorTxPort[0] = 4'h7;
    remoteMirrorEnable[0] = 1'h1;
    send(4'h2, 12'h004, 12'h000);
    chk_copy(cp(2'h0, 5'h04, 1'h1, 4'h7, 1'h1));
    send(4'h2, 12'h008, 12'h000);
    chk_copy(14'h0);
    frmCpuDestMask = 8'h10;
    send(4'h0, 12'h000, 12'h000);
    chk_copy(cp(2'h0, 5'h04, 1'h1, 4'h7, 1'h1));
    $display("t_tx done");
  endtask : t_tx
  task automatic t_prio();
    logic [13:0] p0;
    logic [13:0] p2;
    p0 = cp(2'h0, 5'h01, 1'h0, 4'h0, 1'h0);
    p2 = cp(2'h2, 5'h02, 1'h0, 4'h0, 1'h0);
    clr();
    probeDirection = 6'h22;
    watchedPortMask[0] = 12'h002;
    watchedPortMask[2] = 12'h002;
    usePhysicalIngressPort = 3'h5;
    copyDestPort[0] = 5'h01;
    copyDestPort[2] = 5'h02;
    stationFilterSel[2] = 2'h2;
    frmSrcStationCopy = 1'h1;
    send(4'h1, 12'h000, 12'h000);
    chk_copy(p2);
    frmSrcStationCopy = 1'h0;
    send(4'h1, 12'h000, 12'h000);
    chk_copy(p0);
    stationFilterSel[2] = 2'h1;
    frmFlooded = 1'h1;
    floodedCopyEnable = 1'h1;
    send(4'h1, 12'h000, 12'h000);
    chk_copy(p2);
    floodedCopyEnable = 1'h0;
    send(4'h1, 12'h000, 12'h000);
    chk_copy(p0);
    frmFlooded = 1'h0;
    frmDstStationCopy = 1'h1;
    vlanFilterSel[2] = 2'h1;
    send(4'h1, 12'h000, 12'h000);
    chk_copy(p0);
    frmVlanEntryCopyFlag = 1'h1;
    send(4'h1, 12'h000, 12'h000);
    chk_copy(p2);
    $display("t_prio done");
  endtask : t_prio
  task automatic t_cls();
    clr();
    probeDirection[1] = 2'h2;
    vlanFilterSel[1] = 2'h2;
    matchVlanId[1] = 12'h005;
    copyDestPort[1] = 5'h1f;
    frmClsValid = 1'h1;
    frmClsProbe = 2'h1;
    send(4'h0, 12'h000, 12'h003);
    chk_copy(cp(2'h1, 5'h1f, 1'h0, 4'h0, 1'h0));
    probeDirection[2] = 2'h1;
    copyDestPort[2] = 5'h09;
    mirrorTxPort[2] = 4'h2;
    frmClsProbe = 2'h2;
    send(4'h0, 12'h000, 12'h003);
    chk_copy(cp(2'h2, 5'h09, 1'h1, 4'h2, 1'h0));
    frmClsValid = 1'h0;
    probeDirection[0] = 2'h2;
    cpuVdIngressMask[0] = 9'h100;
    copyDestPort[0] = 5'h03;
    frmCpuVdSrc = 9'h100;
    send(4'h0, 12'h000, 12'h000);
    chk_copy(cp(2'h0, 5'h03, 1'h0, 4'h0, 1'h0));
    $display("t_cls done");
  endtask : t_cls
  // ********************************
  // Run
  // ********************************
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    clr();
    rst_n = 1'h0;
    error_cnt = 0;
    checks = 0;
    expCopies = 0;
    expFwds = 0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'h1;
    t_rst();
    t_rx();
    t_tx();
    t_prio();
    t_cls();
    @(negedge ref_clk);
    chk_val(16'(i_tmps_pipe_model.copyCnt), 16'(expCopies));
    chk_val(16'(i_tmps_pipe_model.fwdCnt), 16'(expFwds));
    close_out();
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
endmodule : tmps_top_bench
`default_nettype wire
